/* sabp_pkg.sv */
// Package for the SDRAM address mux and burst page sequencer
package sabp_pkg;

  // Port size codes
  localparam logic [1:0] PS_32 = 2'h0;
  localparam logic [1:0] PS_16 = 2'h1;

  // Column line counts supported
  localparam logic [3:0] COLS_8 = 4'h8;
  localparam logic [3:0] COLS_9 = 4'h9;
  localparam logic [3:0] COLS_10 = 4'hA;
  localparam logic [3:0] COLS_11 = 4'hB;
  localparam logic [3:0] COLS_13 = 4'hD;

  // Column timing field: 00 -> 1 clock, 01 -> 2, 10 -> 3
  localparam logic [1:0] CTF_RESET = 2'h1;

  // Command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE_ALL_COMMAND = 4'h2;
  localparam logic [3:0] CMD_IDLE = 4'hF;

  // Precharge-all select line of the SDRAM address
  localparam int PRECHARGE_ALL_COMMAND_LINE = 10;

  // Timing in ns and derived clocks at 100 ns period
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_RAS_NS = 48;
  localparam int T_RP_NS = 20;
  localparam logic [3:0] RAS_CYC =
    4'((T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RP_CYC =
    4'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ACT = 3'h1,
    ST_RCD = 3'h3,
    ST_CMD = 3'h2,
    ST_DRAIN = 3'h6,
    ST_RAS = 3'h7,
    ST_PRECHARGE_ALL_COMMAND = 3'h5,
    ST_RP = 3'h4
  } sabp_state_t;

  // Access request from the internal bus
  typedef struct packed {
    logic [23:0] addr;
    logic write;
    logic [3:0] beats;
  } sabp_req_t;

  // Command and address toward the SDRAM pins
  typedef struct packed {
    logic [3:0] cmd;
    logic [13:0] addr;
    logic [1:0] bank;
  } sabp_pins_t;

endpackage : sabp_pkg

/* sabp_addr_mux.sv */
// Row and column address multiplexer
`timescale 1ns/1ps
`default_nettype none
module sabp_addr_mux (
  input wire logic [23:0] cpu_addr, // Internal bus address
  input wire logic [1:0] port_size, // Port size code
  input wire logic [3:0] col_lines, // Column line count
  input wire logic col_phase, // High for column phase
  output logic [13:0] sd_addr // SDRAM address lines
);
  logic [13:0] row_a;
  logic [13:0] col_a;

  always_comb
  begin
    row_a = 14'h0000;
    col_a = 14'h0000;
    if (port_size == sabp_pkg::PS_16)
    begin
      // SDRAM A0 takes row bit A16 and the lowest column bit A1
      for (int i = 0; i < 8; i++)
      begin
        row_a[i] = cpu_addr[16-i];
        col_a[i] = cpu_addr[1+i];
      end
      row_a[10:8] = {cpu_addr[22], cpu_addr[20], cpu_addr[18]};
      col_a[10:8] = {cpu_addr[21], cpu_addr[19], cpu_addr[17]};
    end
    else
    begin
      for (int i = 0; i < 7; i++)
      begin
        row_a[i] = cpu_addr[15-i];
        col_a[i] = cpu_addr[2+i];
      end
      row_a[7] = cpu_addr[17];
      col_a[7] = cpu_addr[16];
      case (col_lines)
        sabp_pkg::COLS_8:
        begin
          row_a[13:8] = cpu_addr[23:18];
        end
        sabp_pkg::COLS_9:
        begin
          row_a[12:8] = cpu_addr[23:19];
          col_a[8] = cpu_addr[18];
        end
        sabp_pkg::COLS_10:
        begin
          row_a[11:8] = {cpu_addr[23:21], cpu_addr[19]};
          col_a[9:8] = {cpu_addr[20], cpu_addr[18]};
        end
        default:
        begin
          row_a[10:8] = {cpu_addr[23], cpu_addr[21], cpu_addr[19]};
          col_a[10:8] = {cpu_addr[22], cpu_addr[20], cpu_addr[18]};
        end
      endcase
    end
  end

  // Row-only lines hold zero in column phase for a stable bus
  assign sd_addr = col_phase ? col_a : row_a;

endmodule // sabp_addr_mux
`default_nettype wire

/* sabp_skid_buf.sv */
// Two-entry buffer for read data with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sabp_skid_buf (
  input wire logic mclk, // Clock
  input wire logic rst, // Async reset, active high
  input wire logic [31:0] in_data, // Incoming word
  input wire logic in_valid, // Incoming word valid
  output logic in_ready, // Space available
  output logic [31:0] out_data, // Outgoing word
  output logic out_valid, // Outgoing word valid
  input wire logic out_ready // Receiver accepts
);
  logic [31:0] mem_reg [sabp_pkg::BUF_DEPTH];
  logic wptr_reg;
  logic rptr_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mem_reg[0] <= 32'h0000_0000;
      mem_reg[1] <= 32'h0000_0000;
    end
    else if (push)
    begin
      mem_reg[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
        wptr_reg <= ~wptr_reg;
      if (pop)
        rptr_reg <= ~rptr_reg;
      cnt_reg <= 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
    end
  end

endmodule // sabp_skid_buf
`default_nettype wire

/* sabp_burst_seq.sv */
// Burst page sequencer with address multiplexing toward SDRAM
`timescale 1ns/1ps
`default_nettype none
// Function
// - 32-bit, 8 columns: A0-A6 from A15-A9, A7 row17/col16, A8-A13 row only
// - 32-bit, 9 columns: A8 row19/col18, A9-A12 row bits 20-23
// - 32-bit, 10 columns: A9 row21/col20, A10-A11 row bits 22, 23
// - 32-bit, 11 columns: A10 carries row bit 23, column bit 22
// - 16-bit, 13 columns: A0-A7 from A16-A9, A8-A10 rows 18/20/22
// - Four-bank part: A20 on SDRAM A10 only for 32-bit, 8 columns, A21 on BA0, A22 on BA1
// - New column address and column strobe every clock within open page; reads hold off once buffered plus in-flight words reach two
// - Transfers wider than port use several commands under one activate
// - First beat gets activate plus command, later beats only command
// - Precharge-all follows the last beat
// - Timing field 01 gives two clocks activate to column strobe
// - Read latency equals that delay; field 01 samples data two later
// - Read burst: NOPs until last data, precharge-all one clock later
// - Write data goes with column strobe, so writes end latency minus one clocks sooner
// - Next access waits for the precharge-to-activate delay
// - Activate, NOPs for row-to-column delay, then read or write commands
// - Pad NOPs for activate-to-precharge, precharge-all, idle clocks
module sabp_burst_seq (
  input wire logic mclk, // Clock, 10 MHz
  input wire logic rst, // Async reset, active high
  input wire sabp_pkg::sabp_req_t req, // Access request
  input wire logic req_valid, // Request valid
  output logic req_ready, // Request taken this cycle
  input wire logic [1:0] port_size, // Port size code
  input wire logic [3:0] col_lines, // Column line count
  input wire logic [1:0] column_timing_field, // Row-to-column and latency
  input wire logic [31:0] wr_data, // Write word for current beat
  output logic wr_take, // Write word consumed
  output sabp_pkg::sabp_pins_t pins, // Command, address, bank
  output logic row_strobe_n, // Row strobe
  output logic column_strobe_n, // Column strobe
  output logic [31:0] dq_out, // Data toward SDRAM
  output logic dq_oe_n, // Data output enable, low drives
  input wire logic [31:0] dq_in, // Data from SDRAM
  output logic [31:0] rd_data, // Read word to receiver
  output logic rd_valid, // Read word valid
  input wire logic rd_ready, // Receiver accepts
  output logic busy // Sequence in progress
);
  sabp_pkg::sabp_state_t state_reg, state_next;
  sabp_pkg::sabp_req_t cur_reg;
  logic [3:0] cnt_reg;
  logic [3:0] beat_reg;
  logic [3:0] ras_reg;
  logic [3:0] lat_reg;
  logic [7:0] rd_pipe_reg;
  logic [31:0] dq_out_reg;
  logic dq_oe_n_reg;
  sabp_pkg::sabp_pins_t pins_reg;
  logic [13:0] mux_addr;
  logic [23:0] beat_addr;
  logic col_phase;
  logic buf_in_ready;
  logic [3:0] cmd_now;
  logic last_beat;
  logic can_issue;
  logic drain_done;
  logic [1:0] buf_occ;
  logic [3:0] in_flight;

  // Field 00 means one clock; delay and latency share one value
  assign lat_reg = 4'({2'h0, column_timing_field} + 4'h1);

  // Each beat advances by the port width in bytes
  assign beat_addr = (port_size == sabp_pkg::PS_16)
                     ? 24'(cur_reg.addr + {19'h0, beat_reg, 1'b0})
                     : 24'(cur_reg.addr + {18'h0, beat_reg, 2'b00});
  assign col_phase = (state_reg == sabp_pkg::ST_CMD);
  assign last_beat = (beat_reg == cur_reg.beats);
  // Words in flight cannot be stalled, so they need reserved buffer room
  assign buf_occ = !buf_in_ready ? 2'h2 : (rd_valid ? 2'h1 : 2'h0);
  assign in_flight = 4'($countones(rd_pipe_reg & 8'((9'h002 << lat_reg[2:0]) - 9'h001)));
  assign can_issue = cur_reg.write || (4'({2'h0, buf_occ} + in_flight) < 4'h2);
  // Last read word is one clock from capture: precharge can follow it
  assign drain_done = (rd_pipe_reg & 8'((8'h01 << (lat_reg - 4'h1)) - 8'h01)) == 8'h00;

  sabp_addr_mux u_mux (
    .cpu_addr(beat_addr),
    .port_size(port_size),
    .col_lines(col_lines),
    .col_phase(col_phase),
    .sd_addr(mux_addr)
  );

  assign req_ready = (state_reg == sabp_pkg::ST_IDLE);
  assign busy = (state_reg != sabp_pkg::ST_IDLE);

  always_comb
  begin
    state_next = state_reg;
    cmd_now = sabp_pkg::CMD_NOP;
    case (state_reg)
      sabp_pkg::ST_IDLE:
      begin
        cmd_now = sabp_pkg::CMD_IDLE;
        if (req_valid)
          state_next = sabp_pkg::ST_ACT;
      end
      sabp_pkg::ST_ACT:
      begin
        cmd_now = sabp_pkg::CMD_ACT;
        state_next = (lat_reg == 4'h1) ? sabp_pkg::ST_CMD : sabp_pkg::ST_RCD;
      end
      sabp_pkg::ST_RCD:
      begin
        if (cnt_reg == 4'h1)
          state_next = sabp_pkg::ST_CMD;
      end
      sabp_pkg::ST_CMD:
      begin
        if (can_issue)
        begin
          cmd_now = cur_reg.write ? sabp_pkg::CMD_WR : sabp_pkg::CMD_RD;
          if (last_beat)
            state_next = cur_reg.write ? sabp_pkg::ST_RAS : sabp_pkg::ST_DRAIN;
        end
      end
      sabp_pkg::ST_DRAIN:
      begin
        // NOPs until last read word is captured
        if (drain_done && ras_reg >= sabp_pkg::RAS_CYC)
          state_next = sabp_pkg::ST_PRECHARGE_ALL_COMMAND;
      end
      sabp_pkg::ST_RAS:
      begin
        if (ras_reg >= sabp_pkg::RAS_CYC)
          state_next = sabp_pkg::ST_PRECHARGE_ALL_COMMAND;
      end
      sabp_pkg::ST_PRECHARGE_ALL_COMMAND:
      begin
        cmd_now = sabp_pkg::CMD_PRECHARGE_ALL_COMMAND;
        state_next = sabp_pkg::ST_RP;
      end
      sabp_pkg::ST_RP:
      begin
        if (cnt_reg <= 4'h1)
          state_next = sabp_pkg::ST_IDLE;
      end
      default:
      begin
        state_next = sabp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_reg <= sabp_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cur_reg <= '0;
    else if (req_valid && req_ready)
      cur_reg <= req;
  end

  // Delay counter for row-to-column and precharge waits
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cnt_reg <= 4'h0;
    else if (state_reg == sabp_pkg::ST_ACT)
      cnt_reg <= 4'(lat_reg - 4'h1);
    else if (state_reg == sabp_pkg::ST_PRECHARGE_ALL_COMMAND)
      cnt_reg <= sabp_pkg::RP_CYC;
    else if (cnt_reg != 4'h0)
      cnt_reg <= 4'(cnt_reg - 4'h1);
  end

  // Clocks since activate, for the activate-to-precharge minimum
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ras_reg <= 4'h0;
    else if (state_reg == sabp_pkg::ST_ACT)
      ras_reg <= 4'h1;
    else if (ras_reg != 4'hF)
      ras_reg <= 4'(ras_reg + 4'h1);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      beat_reg <= 4'h0;
    else if (req_valid && req_ready)
      beat_reg <= 4'h0;
    else if (col_phase && can_issue && !last_beat)
      beat_reg <= 4'(beat_reg + 4'h1);
  end

  // Pin outputs registered; bank lines A21/A22 fixed for four-bank part
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pins_reg <= '{cmd: sabp_pkg::CMD_IDLE, addr: 14'h0000, bank: 2'h0};
    else
    begin
      pins_reg.cmd <= cmd_now;
      pins_reg.bank <= beat_addr[22:21];
      if (cmd_now == sabp_pkg::CMD_PRECHARGE_ALL_COMMAND)
        pins_reg.addr <= 14'(1 << sabp_pkg::PRECHARGE_ALL_COMMAND_LINE);
      else
        pins_reg.addr <= mux_addr;
    end
  end

  assign pins = pins_reg;
  assign row_strobe_n = pins_reg.cmd[2];
  assign column_strobe_n = pins_reg.cmd[1];

  // Write data leaves with the column strobe
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dq_out_reg <= 32'h0000_0000;
      dq_oe_n_reg <= 1'b1;
    end
    else
    begin
      dq_oe_n_reg <= !(cmd_now == sabp_pkg::CMD_WR);
      if (cmd_now == sabp_pkg::CMD_WR)
        dq_out_reg <= wr_data;
    end
  end

  assign dq_out = dq_out_reg;
  assign dq_oe_n = dq_oe_n_reg;
  assign wr_take = (cmd_now == sabp_pkg::CMD_WR);

  // Read capture lat clocks after column strobe on the pins
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rd_pipe_reg <= 8'h00;
    else
      rd_pipe_reg <= {rd_pipe_reg[6:0], cmd_now == sabp_pkg::CMD_RD};
  end

  sabp_skid_buf u_buf (
    .mclk(mclk),
    .rst(rst),
    .in_data(dq_in),
    .in_valid(rd_pipe_reg[lat_reg[2:0]]),
    .in_ready(buf_in_ready),
    .out_data(rd_data),
    .out_valid(rd_valid),
    .out_ready(rd_ready)
  );

  property p_act_to_cas2;
    @(posedge mclk) disable iff (rst)
      (pins.cmd == sabp_pkg::CMD_ACT && column_timing_field == 2'h1)
      |-> ##1 column_strobe_n ##1 !column_strobe_n;
  endproperty
  a_act_to_cas2: assert property (p_act_to_cas2) else $error("delay not 2");

  property p_precharge_all_command_after_read;
    @(posedge mclk) disable iff (rst)
      (rd_pipe_reg == 8'(8'h01 << lat_reg[2:0]) && last_beat && !cur_reg.write
       && state_reg != sabp_pkg::ST_CMD)
      |-> ##1 pins.cmd == sabp_pkg::CMD_PRECHARGE_ALL_COMMAND;
  endproperty
  a_precharge_all_command_after_read: assert property (p_precharge_all_command_after_read) else $error("late precharge_all_command");

  sequence s_precharge_all_command;
    pins.cmd == sabp_pkg::CMD_PRECHARGE_ALL_COMMAND;
  endsequence
  sequence s_quiet;
    pins.cmd != sabp_pkg::CMD_ACT;
  endsequence
  property p_rp;
    @(posedge mclk) disable iff (rst) s_precharge_all_command |-> ##1 s_quiet;
  endproperty
  a_rp: assert property (p_rp) else $error("activate too soon");

  property p_precharge_all_command_line;
    @(posedge mclk) disable iff (rst)
      s_precharge_all_command |-> pins.addr[sabp_pkg::PRECHARGE_ALL_COMMAND_LINE];
  endproperty
  a_precharge_all_command_line: assert property (p_precharge_all_command_line) else $error("precharge_all_command line low");

  property p_wr_data;
    @(posedge mclk) disable iff (rst)
      pins.cmd == sabp_pkg::CMD_WR |-> !dq_oe_n && dq_out == $past(wr_data);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data late");

  property p_one_act;
    @(posedge mclk) disable iff (rst)
      (state_reg == sabp_pkg::ST_CMD) |-> cmd_now != sabp_pkg::CMD_ACT;
  endproperty
  a_one_act: assert property (p_one_act) else $error("extra activate");

  property p_col_step;
    @(posedge mclk) disable iff (rst)
      (col_phase && can_issue && !last_beat) ##1 can_issue
      |-> beat_reg == $past(beat_reg) + 4'h1;
  endproperty
  a_col_step: assert property (p_col_step) else $error("no address step");

  property p_ras_min;
    @(posedge mclk) disable iff (rst)
      s_precharge_all_command |-> $past(ras_reg) >= sabp_pkg::RAS_CYC;
  endproperty
  a_ras_min: assert property (p_ras_min) else $error("ras short");

endmodule // sabp_burst_seq
`default_nettype wire

/* sabp_sdram_model.sv */
// Far-side SDRAM model: one word per command, programmable read latency
`timescale 1ns/1ps
`default_nettype none
module sabp_sdram_model (
  input wire logic mclk, // Clock
  input wire sabp_pkg::sabp_pins_t pins, // Command, address, bank
  input wire logic [31:0] dq_out, // Data from controller
  input wire logic [1:0] column_timing_field, // Latency code
  output logic [31:0] dq_in // Data to controller
);
  logic [31:0] mem [int];
  logic [31:0] pipe [4];
  logic [31:0] junk;
  int key;
  initial
  begin
    junk = 32'h5A5A5A5A;
    foreach (pipe[i])
      pipe[i] = 32'h0;
  end
  // Bus never holds stale data: junk changes every cycle
  assign dq_in = pipe[column_timing_field];
  always @(posedge mclk)
  begin
    key = {pins.bank, pins.addr};
    junk <= ~junk + 32'h1;
    if (pins.cmd == sabp_pkg::CMD_WR)
      mem[key] = dq_out;
    if (pins.cmd == sabp_pkg::CMD_RD && mem.exists(key))
      pipe[0] <= mem[key];
    else
      pipe[0] <= junk;
    for (int i = 1; i < 4; i++)
      pipe[i] <= pipe[i-1];
  end
endmodule // sabp_sdram_model
`default_nettype wire

/* sdram_addr_mux_burst_page_test.sv */
// Self-checking bench for the burst page sequencer
`timescale 1ns/1ps
`default_nettype none
module sdram_addr_mux_burst_page_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  sabp_pkg::sabp_req_t req, cur;
  sabp_pkg::sabp_pins_t pins;
  logic req_valid, req_ready, wr_take, row_strobe_n, column_strobe_n;
  logic dq_oe_n, rd_valid, rd_ready, busy;
  logic [1:0] port_size, column_timing_field;
  logic [3:0] col_lines;
  logic [31:0] wr_data, dq_out, dq_in, rd_data;
  logic [31:0] wq[$], exp_q[$], bmem[int];
  logic [13:0] m;
  logic [23:0] ba;
  int n_errors = 0, checks = 0, cyc = 0, precharge_all_command_c = -100;
  int act_c, last_c, bt, widx, lat, stall = 0;
  sabp_burst_seq sabp_burst_seq_i (.mclk(mclk), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .port_size(port_size),
    .col_lines(col_lines), .column_timing_field(column_timing_field),
    .wr_data(wr_data), .wr_take(wr_take), .pins(pins), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dq_in(dq_in), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .busy(busy));
  sabp_sdram_model sabp_sdram_model_i (.mclk(mclk), .pins(pins), .dq_out(dq_out),
    .column_timing_field(column_timing_field), .dq_in(dq_in));
  always #50 mclk = ~mclk;
  task automatic cmp_val(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_gap(input int got, input int exp);
    cmp_val(40'(got), 40'(exp));
  endtask
  task automatic print_verdict;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [13:0] mux(input logic [23:0] a, input logic c,
    input logic [1:0] ps, input logic [3:0] cl);
    logic [13:0] s;
    s = '0;
    if (ps == sabp_pkg::PS_16)
    begin
      for (int i = 0; i < 8; i++)
        s[i] = c ? a[1+i] : a[16-i];
      for (int i = 0; i < 3; i++)
        s[8+i] = c ? a[17+2*i] : a[18+2*i];
    end
    else
    begin
      for (int i = 0; i < 7; i++)
        s[i] = c ? a[2+i] : a[15-i];
      s[7] = c ? a[16] : a[17];
      for (int i = 8; i < 14; i++)
        if (i < cl)
          s[i] = c ? a[2*i+2] : a[2*i+3];
        else if (i + cl + 2 < 24)
          s[i] = c ? 1'b0 : a[i+cl+2];
    end
    return s;
  endfunction
  // Pin monitor and read-data scoreboard
  always @(posedge mclk)
  begin
    cyc++;
    if (wr_take === 1'b1)
      widx++;
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      cmp_val(rd_data, exp_q.size() ? exp_q.pop_front() : 32'hDEADBEEF);
    m = 14'h3FFF >> (14 - (cur.write === 1'bx ? 14 : 0));
    m = 14'h3FFF >> (14 - (port_size == sabp_pkg::PS_16 ? 11 : 22 - col_lines));
    ba = cur.addr + 24'(bt * (port_size == sabp_pkg::PS_16 ? 2 : 4));
    if (!rst)
    begin
      cmp_val({row_strobe_n, column_strobe_n}, pins.cmd[2:1]);
      case (pins.cmd)
        sabp_pkg::CMD_ACT:
        begin
          cmp_gap(int'(cyc - precharge_all_command_c > sabp_pkg::RP_CYC), 1);
          cmp_val({pins.bank, pins.addr & m},
            {cur.addr[22:21], mux(cur.addr, 1'b0, port_size, col_lines) & m});
          act_c = cyc;
          bt = 0;
        end
        sabp_pkg::CMD_RD, sabp_pkg::CMD_WR:
        begin
          if (bt == 0)
            cmp_gap(cyc - act_c, lat);
          else if (cur.write)
            cmp_gap(cyc - last_c, 1);
          cmp_val({pins.cmd, pins.bank, pins.addr & m},
            {cur.write ? sabp_pkg::CMD_WR : sabp_pkg::CMD_RD, ba[22:21],
             mux(ba, 1'b1, port_size, col_lines) & m});
          if (cur.write)
            cmp_val({dq_oe_n, dq_out}, {1'b0, wq[bt]});
          last_c = cyc;
          bt++;
        end
        sabp_pkg::CMD_PRECHARGE_ALL_COMMAND:
        begin
          cmp_val(pins.addr, 14'h0400);
          cmp_gap(bt, cur.beats + 1);
          cmp_gap(int'(cyc - act_c > sabp_pkg::RAS_CYC), 1);
          if (!cur.write)
            cmp_gap(cyc - last_c, lat + 1);
          else
            cmp_gap(int'(cyc - last_c <= 2), 1);
          precharge_all_command_c = cyc;
        end
        default:
        begin
        end
      endcase
    end
  end
  // Receiver stalls at random, and for a long spell on request
  always @(negedge mclk)
  begin
    wr_data <= widx < wq.size() ? wq[widx] : $urandom;
    rd_ready <= stall == 0 && $urandom % 4 != 0;
    if (stall > 0)
      stall--;
  end
  task automatic access(input logic w, input logic [23:0] a, input int nb,
    input logic [1:0] ps, input logic [3:0] cl, input logic [1:0] f, input int st);
    int k;
    k = 0;
    @(negedge mclk);
    while (req_ready !== 1'b1 && k < 200)
    begin
      @(negedge mclk);
      k++;
    end
    cmp_val(busy, 1'b0);
    port_size = ps;
    col_lines = cl;
    column_timing_field = f;
    lat = f + 1;
    cur = '{addr: a, write: w, beats: 4'(nb - 1)};
    widx = 0;
    if (w)
      wq = {};
    for (int i = 0; i < nb; i++)
      if (w)
      begin
        wq.push_back($urandom);
        bmem[a + i * (ps == sabp_pkg::PS_16 ? 2 : 4)] = wq[i];
      end
      else
        exp_q.push_back(bmem[a + i * (ps == sabp_pkg::PS_16 ? 2 : 4)]);
    @(negedge mclk);
    stall = st;
    req = cur;
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
  endtask
  initial
  begin
    logic [3:0] cls [5];
    logic [23:0] a;
    int nb;
    cls = '{sabp_pkg::COLS_8, sabp_pkg::COLS_9, sabp_pkg::COLS_10,
            sabp_pkg::COLS_11, sabp_pkg::COLS_13};
    req = '0;
    req_valid = 1'b0;
    port_size = sabp_pkg::PS_32;
    col_lines = sabp_pkg::COLS_8;
    column_timing_field = sabp_pkg::CTF_RESET;
    wr_data = 32'h0;
    rd_ready = 1'b1;
    widx = 0;
    bt = 0;
    cur = '0;
    void'($urandom(32'h5A3A));
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int c = 0; c < 5; c++)
      for (int f = 0; f < 3; f++)
      begin
        a = ($urandom & 24'hFFFE00) | ($urandom & (c == 4 ? 24'hE : 24'h1C));
        nb = (c == 2 && f == 1) ? 8 : 1 + $urandom % 8;
        access(1'b1, a, nb, c == 4 ? sabp_pkg::PS_16 : sabp_pkg::PS_32, cls[c], 2'(f), 0);
        // Long stall fills the two-entry buffer so RD issue must hold off
        access(1'b0, a, nb, c == 4 ? sabp_pkg::PS_16 : sabp_pkg::PS_32, cls[c], 2'(f),
          (c == 2 && f == 1) ? 30 : 0);
      end
    repeat (200)
      if (exp_q.size() != 0 || busy !== 1'b0)
        @(negedge mclk);
    cmp_gap(exp_q.size(), 0);
    print_verdict();
  end
  initial
  begin
    #500us;
    n_errors++;
    print_verdict();
  end
endmodule // sdram_addr_mux_burst_page_test
`default_nettype wire
